// [bench/brs_feed_model.sv]
`timescale 1ns/1ps
`default_nettype none
// feed code: 0 low rail, 1 high rail, 2 ringing rail switched onto the supply
module brs_feed_model (
  input wire rail_select_ch_a,
  input wire ringing_rail_output,
  output logic [1:0] feed_a
);
  assign feed_a = ringing_rail_output ? 2'd2 : {1'b0, rail_select_ch_a};
endmodule // brs_feed_model
`default_nettype wire

// [bench/brs_rail_switch_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module brs_rail_switch_chk (
  input wire clk,
  input wire rst,
  input wire [3:0] addr,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  input wire offhook_a,
  input wire offhook_b,
  input wire ringing_a,
  input wire ringing_b,
  input wire ring_cadence_on,
  input wire rail_select_ch_a,
  input wire rail_select_ch_b,
  input wire ringing_rail_output
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("rdata not zero outside read");
  a_ctrl_upper_zero: assert property ($past(rd) && $past(addr) == 4'h0 |-> rdata[15:7] == 9'h000)
    else $error("relay control upper bits set");
  a_indicator_match: assert property ($past(rd) && $past(addr) == 4'h0 |->
    rdata[4] == $past(rail_select_ch_a) && rdata[5] == $past(rail_select_ch_b)
    && rdata[6] == $past(ringing_rail_output)) else $error("indicator mismatch");
  a_coef_low_zero: assert property ($past(rd) && $past(addr) == 4'h3 |-> rdata[2:0] == 3'h0)
    else $error("coefficient low bits set");
  a_ring_needs_ringing: assert property (!$past(ringing_a || ringing_b) |-> !ringing_rail_output)
    else $error("ringing rail without ringing");
  a_ring_needs_cadence: assert property (!$past(ring_cadence_on) |-> !ringing_rail_output)
    else $error("ringing rail off cadence");
  a_low_a_cause: assert property ($fell(rail_select_ch_a) |-> $past(offhook_a) ||
    $past(offhook_a, 2) || $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("channel a dropped rail without cause");
  a_low_b_cause: assert property ($fell(rail_select_ch_b) |-> $past(offhook_b) ||
    $past(offhook_b, 2) || $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("channel b dropped rail without cause");
endmodule // brs_rail_switch_chk
bind brs_rail_switch brs_rail_switch_chk u_chk (.clk(clk), .rst(rst), .addr(addr), .wr(wr),
  .rd(rd), .rdata(rdata), .offhook_a(offhook_a), .offhook_b(offhook_b), .ringing_a(ringing_a),
  .ringing_b(ringing_b), .ring_cadence_on(ring_cadence_on), .rail_select_ch_a(rail_select_ch_a),
  .rail_select_ch_b(rail_select_ch_b), .ringing_rail_output(ringing_rail_output));
`default_nettype wire

// [bench/brs_rail_switch_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "brs_consts.vh"
module brs_rail_switch_tb_top;
  logic clk = 0, rst = 1, wr = 0, rd = 0, sample_valid = 0, offhook_a = 0, offhook_b = 0;
  logic ringing_a = 0, ringing_b = 0, ring_cadence_on = 0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, vtr_mag_a = 16'h0000, vtr_mag_b = 16'h0000;
  wire [15:0] rdata;
  wire sel_a, sel_b, ring_out;
  wire [1:0] feed_a;
  int num_errors = 0, comparisons = 0;
  always #5 clk = ~clk;
  brs_rail_switch uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sample_valid(sample_valid), .vtr_mag_a(vtr_mag_a), .vtr_mag_b(vtr_mag_b),
    .offhook_a(offhook_a), .offhook_b(offhook_b), .ringing_a(ringing_a), .ringing_b(ringing_b),
    .ring_cadence_on(ring_cadence_on), .rail_select_ch_a(sel_a), .rail_select_ch_b(sel_b),
    .ringing_rail_output(ring_out));
  brs_feed_model u_feed (.rail_select_ch_a(sel_a), .ringing_rail_output(ring_out),
    .feed_a(feed_a));
  ////////////////////////////////////////
  task chk(input string n, input [15:0] s, input [15:0] e);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task bw(input [3:0] a, input [15:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task br(input [3:0] a, input [15:0] e);
    @(posedge clk);
    addr <= a; rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", rdata, e);
  endtask
  // decision lands one edge after the filter edge, so three edges is ample
  task settle(input [2:0] e);
    repeat (3) @(posedge clk);
    #1 chk("rails", {13'h0000, ring_out, sel_b, sel_a}, {13'h0000, e});
  endtask
  task smp(input [15:0] v, input [2:0] e);
    @(posedge clk);
    vtr_mag_a <= v; sample_valid <= 1;
    @(posedge clk);
    sample_valid <= 0;
    settle(e);
  endtask
  ////////////////////////////////////////
  task t_reset;
    br(`BRS_ADDR_RELAY_CTRL, 16'h0031);
    br(`BRS_ADDR_LPF_COEF, 16'h0A10);
    br(`BRS_ADDR_HI_TH, 16'h0000);
    br(`BRS_ADDR_LO_TH, 16'h0000);
    br(4'hF, 16'h0000);
    // 2*pi*10*4096/800 rounds to 322, which sits in bits 15:3 as 0a10
    bw(`BRS_ADDR_LPF_COEF, 16'h0A10);
    br(`BRS_ADDR_LPF_COEF, 16'h0A10);
    bw(4'hF, 16'hFFFF);
    br(4'hF, 16'h0000);
  endtask
  task t_manual;
    bw(`BRS_ADDR_RELAY_CTRL, 16'h0002);
    settle(3'b001);
    br(`BRS_ADDR_RELAY_CTRL, 16'h0012);
    bw(`BRS_ADDR_RELAY_CTRL, 16'h0004);
    settle(3'b010);
  endtask
  task t_auto;
    bw(`BRS_ADDR_LPF_COEF, 16'h4000);
    bw(`BRS_ADDR_LO_TH, 16'h1000);
    bw(`BRS_ADDR_HI_TH, 16'h2000);
    bw(`BRS_ADDR_RELAY_CTRL, 16'h0001);
    settle(3'b011);
    offhook_a <= 1;
    smp(16'h0800, 3'b010);
    br(`BRS_ADDR_VTR_A, 16'h0800);
    smp(16'h3000, 3'b011);
    smp(16'h1800, 3'b011);
    smp(16'h0800, 3'b010);
    offhook_a <= 0;
    settle(3'b011);
    bw(`BRS_ADDR_LPF_COEF, 16'h0000);
    smp(16'h3000, 3'b011);
    br(`BRS_ADDR_VTR_A, 16'h0800);
  endtask
  task t_ring;
    bw(`BRS_ADDR_RELAY_CTRL, 16'h0009);
    ringing_a <= 1; ring_cadence_on <= 1;
    settle(3'b111);
    chk("feed", {14'h0000, feed_a}, 16'h0002);
    ring_cadence_on <= 0;
    settle(3'b011);
    ring_cadence_on <= 1;
    bw(`BRS_ADDR_RELAY_CTRL, 16'h0001);
    settle(3'b011);
  endtask
  // channel b on its own voltage, ringing hold, read-only control bits
  task t_chan_b;
    bw(`BRS_ADDR_LPF_COEF, 16'h4000);
    vtr_mag_b <= 16'h0800;
    offhook_b <= 1;
    smp(16'h3000, 3'b001);
    br(`BRS_ADDR_VTR_B, 16'h0800);
    ringing_b <= 1;
    settle(3'b011);
    bw(`BRS_ADDR_RELAY_CTRL, 16'h00F1);
    br(`BRS_ADDR_RELAY_CTRL, 16'h0031);
    ringing_b <= 0;
    offhook_b <= 0;
    settle(3'b011);
  endtask
  task final_report;
    $display("num_errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    t_reset;
    t_manual;
    t_auto;
    t_ring;
    t_chan_b;
    final_report;
  end
endmodule // brs_rail_switch_tb_top
`default_nettype wire

// [pkg/brs_consts.vh]
`ifndef BRS_CONSTS_VH
`define BRS_CONSTS_VH
// register addresses (plain port, 4-bit address)
`define BRS_ADDR_RELAY_CTRL 4'h0
`define BRS_ADDR_HI_TH 4'h1
`define BRS_ADDR_LO_TH 4'h2
`define BRS_ADDR_LPF_COEF 4'h3
`define BRS_ADDR_VTR_A 4'h4
`define BRS_ADDR_VTR_B 4'h5
// relay control fields
`define BRS_RC_AUTO 0
`define BRS_RC_MAN_A 1
`define BRS_RC_MAN_B 2
`define BRS_RC_THIRD 3
`define BRS_RC_IND_A 4
`define BRS_RC_IND_B 5
`define BRS_RC_RING_OUT 6
// field positions
`define BRS_TH_MSB 14
`define BRS_TH_LSB 7
`define BRS_COEF_MSB 15
`define BRS_COEF_LSB 3
// reset values
`define BRS_RC_RESET 8'h01
`define BRS_HI_TH_RESET 16'h0000
`define BRS_LO_TH_RESET 16'h0000
`define BRS_COEF_RESET 16'h0A10
`endif

// [rtl/brs_chan.v]
`timescale 1ns/1ps
`default_nettype none
`include "brs_consts.vh"
// one channel: low-pass filter plus hysteretic rail decision
module brs_chan (
  input wire clk,
  input wire rst,
  input wire sample_valid,
  input wire [15:0] vtr_mag,
  input wire [15:0] coef,
  input wire [15:0] hi_th,
  input wire [15:0] lo_th,
  input wire auto_en,
  input wire manual_sel,
  input wire offhook,
  input wire ringing,
  output reg rail_high_reg,
  output wire [15:0] filt_out
);
  reg [15:0] filt_reg;
  wire [12:0] k;
  wire signed [17:0] diff;
  wire signed [31:0] prod;
  wire signed [17:0] step;
  wire [15:0] filt_next;
  wire [7:0] filt_step;
  reg offhook_d_reg;
  reg rail_high_next;

  // coefficient in 15:3, 4000h (k=2048) means unfiltered, 0 blocks all [R10]
  assign k = coef[`BRS_COEF_MSB:`BRS_COEF_LSB];
  assign diff = $signed({2'b00, vtr_mag}) - $signed({2'b00, filt_reg});
  assign prod = diff * $signed({1'b0, k});
  assign step = prod[28:11];
  assign filt_next = (k >= 13'h0800) ? vtr_mag : filt_reg + step[15:0];
  assign filt_out = filt_reg;
  // thresholds compare in 628 mV steps (bits 14:7) [R12] [R13]
  assign filt_step = filt_reg[`BRS_TH_MSB:`BRS_TH_LSB];

  // filter runs continuously on every sample [R04] [R17]
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_reg <= 16'h0000;
      offhook_d_reg <= 1'b0;
    end else begin
      if (sample_valid) begin
        filt_reg <= filt_next;
      end
      offhook_d_reg <= offhook;
    end
  end

  always @* begin
    rail_high_next = rail_high_reg;
    if (!auto_en) begin
      rail_high_next = manual_sel; // [R02]
    end else if (!offhook || ringing) begin
      rail_high_next = 1'b1; // on-hook or ringing sits on the high rail [R05] [R06]
    end else if (rail_high_reg && filt_step < lo_th[`BRS_TH_MSB:`BRS_TH_LSB]) begin
      rail_high_next = 1'b0; // enough overhead, drop to low rail [R03] [R07] [R08]
    end else if (!rail_high_reg && filt_step > hi_th[`BRS_TH_MSB:`BRS_TH_LSB]) begin
      rail_high_next = 1'b1; // hysteresis band holds state in between [R17]
    end
  end

  // high level selects the high rail, low the low rail [R01]
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rail_high_reg <= 1'b1;
    end else begin
      rail_high_reg <= rail_high_next;
    end
  end
endmodule // brs_chan
`default_nettype wire

// [rtl/brs_rail_switch.v]
// Operation
// R01 - rail select low means low rail, high means high rail
// R02 - both channels' rail select governed by relay control bits
// R03 - auto mode drops to low rail when off-hook voltage allows
// R04 - monitor tip-ring voltage continuously, pick lowest sufficient rail
// R05 - ringing variant: high rail on-hook, low rail after off-hook
// R06 - low to high rail on off-hook to on-hook using high threshold; code goes high on on-hook without the threshold
// R07 - high to low rail on going off-hook using low threshold
// R08 - high to low rail during active off-hook when overhead allows
// R09 - host computes coefficient as 2*pi*f*4096/800
// R10 - coefficient in bits 15:3; zero blocks, 4000h passes unfiltered
// R11 - host should program about 10 Hz, coefficient 0A10h
// R12 - high threshold in bits 14:7, 628 mV per step
// R13 - low threshold in bits 14:7, 628 mV per step
// R14 - third rail bit set drives ringing rail output with cadence
// R15 - ringing rail output asserted while ringing is active
// R16 - host should keep automatic switching enabled on ringing variant
// R17 - per-channel filtered voltage and rail state with hysteresis
// R18 - indicator bit reads back selected rail, no read side effect
`timescale 1ns/1ps
`default_nettype none
`include "brs_consts.vh"
module brs_rail_switch (
  input wire clk,
  input wire rst,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  input wire sample_valid,
  input wire [15:0] vtr_mag_a,
  input wire [15:0] vtr_mag_b,
  input wire offhook_a,
  input wire offhook_b,
  input wire ringing_a,
  input wire ringing_b,
  input wire ring_cadence_on,
  output wire rail_select_ch_a,
  output wire rail_select_ch_b,
  output reg ringing_rail_output
);
  ////////////////////////////////////////////////////////////////////////
  reg [7:0] relay_control_reg;
  reg [15:0] high_rail_threshold_reg;
  reg [15:0] low_rail_threshold_reg;
  reg [15:0] rail_filter_coefficient_reg;
  wire [15:0] filt_a;
  wire [15:0] filt_b;
  wire sel_a;
  wire sel_b;
  reg [15:0] rdata_next;

  function hit;
    input [3:0] a;
    input [3:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  // writable bits only; indicator bits are live state, not stored
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      relay_control_reg <= `BRS_RC_RESET;
      high_rail_threshold_reg <= `BRS_HI_TH_RESET;
      low_rail_threshold_reg <= `BRS_LO_TH_RESET;
      rail_filter_coefficient_reg <= `BRS_COEF_RESET;
    end else if (wr) begin
      if (hit(addr, `BRS_ADDR_RELAY_CTRL)) begin
        relay_control_reg <= {4'h0, wdata[3:0]};
      end
      if (hit(addr, `BRS_ADDR_HI_TH)) begin
        high_rail_threshold_reg <= wdata;
      end
      if (hit(addr, `BRS_ADDR_LO_TH)) begin
        low_rail_threshold_reg <= wdata;
      end
      if (hit(addr, `BRS_ADDR_LPF_COEF)) begin
        rail_filter_coefficient_reg <= {wdata[15:3], 3'b000}; // [R10]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    rdata_next = 16'h0000;
    if (hit(addr, `BRS_ADDR_RELAY_CTRL)) begin
      // indicators reflect the rail actually driven, reads change nothing [R18]
      rdata_next = {9'h000, ringing_rail_output, sel_b, sel_a, relay_control_reg[3:0]};
    end else if (hit(addr, `BRS_ADDR_HI_TH)) begin
      rdata_next = high_rail_threshold_reg;
    end else if (hit(addr, `BRS_ADDR_LO_TH)) begin
      rdata_next = low_rail_threshold_reg;
    end else if (hit(addr, `BRS_ADDR_LPF_COEF)) begin
      rdata_next = rail_filter_coefficient_reg;
    end else if (hit(addr, `BRS_ADDR_VTR_A)) begin
      rdata_next = filt_a;
    end else if (hit(addr, `BRS_ADDR_VTR_B)) begin
      rdata_next = filt_b;
    end
  end

  // read data valid only the cycle after the strobe, zero otherwise
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      rdata <= rdata_next;
    end else begin
      rdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  brs_chan u_chan_a (
    .clk(clk),
    .rst(rst),
    .sample_valid(sample_valid),
    .vtr_mag(vtr_mag_a),
    .coef(rail_filter_coefficient_reg),
    .hi_th(high_rail_threshold_reg),
    .lo_th(low_rail_threshold_reg),
    .auto_en(relay_control_reg[`BRS_RC_AUTO]),
    .manual_sel(relay_control_reg[`BRS_RC_MAN_A]),
    .offhook(offhook_a),
    .ringing(ringing_a),
    .rail_high_reg(sel_a),
    .filt_out(filt_a)
  );

  brs_chan u_chan_b (
    .clk(clk),
    .rst(rst),
    .sample_valid(sample_valid),
    .vtr_mag(vtr_mag_b),
    .coef(rail_filter_coefficient_reg),
    .hi_th(high_rail_threshold_reg),
    .lo_th(low_rail_threshold_reg),
    .auto_en(relay_control_reg[`BRS_RC_AUTO]),
    .manual_sel(relay_control_reg[`BRS_RC_MAN_B]),
    .offhook(offhook_b),
    .ringing(ringing_b),
    .rail_high_reg(sel_b),
    .filt_out(filt_b)
  );

  assign rail_select_ch_a = sel_a; // [R01] [R02]
  assign rail_select_ch_b = sel_b; // [R01] [R02]

  // third rail only switched when present; follows live cadence [R14] [R15]
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ringing_rail_output <= 1'b0;
    end else begin
      ringing_rail_output <= relay_control_reg[`BRS_RC_THIRD] & ring_cadence_on
        & (ringing_a | ringing_b);
    end
  end
endmodule // brs_rail_switch
`default_nettype wire
